//--- fieldbus_exchange_memory.sv
`include "xchg_defs.svh"
// Function
// - internal 5000-byte exchange memory between serial and hart sides
// - bytes 0..2999 hold input data and status, read-only from bus
// - bytes 3000..4999 hold outputs and controls, bus read-write
// - register n maps byte 2n high and byte 2n+1 low
// - input area holds slave replies, output area holds data sent
// - first access to a slave runs identity command, reply in 20-byte slot
// - gateway state: 0 idle, 1 sending, 2 waiting, 3 handling
// - sent, received and error byte counters follow the state byte
// - command status: 0 none,1 ok,2 parity,3 no answer,4 proto,5 absent
// - writing a new value to clear control zeroes the three counters
// - poll enable byte read-write, 1 enables cyclic polling, 0 disables
// - trigger label change runs the selected user command once
// - triggered reply stored in that command's receive region
// - pass-through works only while its enable byte equals 1
// - each send label change sends one frame of given length, capped at 300 bytes
// - received frame bytes written before, and length in the same cycle as, the receive label change
// - missing pass-through reply bumps the receive error counter
// - serial frames split by 3.5-char idle
// - idle timeout is 3.5 chars of 10 bits at the set baud
`timescale 1ns/1ps
`default_nettype none
module fieldbus_exchange_memory
  import xchg_pkg::*;
#(
  parameter int          BAUD        = 19200,
  parameter int          MEM_SIZE    = `MEM_BYTES,
  parameter logic [15:0] IDENT_LEN   = 16'd20,
  parameter logic [12:0] USER_RX_BASE = 13'd0,
  parameter logic [12:0] USER_RX_SIZE = 13'd20
) (
  // system
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // register port, one 16-bit register per access
  input  wire bus_req_t   bus_req,
  output var  logic [15:0] bus_rdata,
  output var  logic       bus_rvalid,
  // serial side, raw byte stream for universal serial mode
  input  wire logic       ser_mode_universal,
  input  wire hart_byte_t ser_rx,
  output var  logic       ser_frame_end,
  // hart transmit stream
  output var  hart_byte_t hart_tx,
  input  wire logic       hart_tx_ready,
  output var  logic [7:0] hart_cmd,
  output var  logic       hart_cmd_start,
  output var  logic [3:0] hart_slave,
  output var  logic       hart_ident,
  // hart receive stream and outcome
  input  wire hart_byte_t hart_rx,
  input  wire hart_done_t hart_done,
  input  wire logic [3:0] cmd_slave,
  input  wire logic       cmd_req,
  input  wire logic [7:0] cmd_req_num,
  // status
  output var  logic       poll_enabled,
  output var  gw_state_t  gw_state
);
  // ==========================================================
  // constants and helpers
  // ==========================================================
  localparam int IDLE_CYC_I =
    (`CLK_HZ / BAUD) * `BITS_PER_CHAR * `IDLE_TENTH_BITS / 10;
  localparam logic [15:0] IDLE_CYC = 16'(IDLE_CYC_I);

  // byte address of a register half
  function automatic logic [12:0] hi_byte(input logic [11:0] r);
    return {r, 1'b0};
  endfunction

  function automatic logic [7:0] bump(input logic [7:0] v);
    return 8'(v + 8'h01);
  endfunction

  // ==========================================================
  // exchange memory
  // ==========================================================
  logic [7:0] mem [0:MEM_SIZE-1];
  logic [7:0] ctl_clr, ctl_poll, ctl_trig, ctl_tcmd, ctl_ptx, ctl_pen;
  logic [15:0] ctl_plen;
  logic [7:0] tx_byte;

  state_t s_q, s_d;

  // hart-side write port
  logic        hw_en;
  logic [12:0] hw_addr;
  logic [7:0]  hw_data;

  logic bus_wr_ok;
  logic [12:0] wa;
  assign wa = hi_byte(bus_req.reg_addr);
  assign bus_wr_ok = bus_req.wr && wa >= `RW_FIRST &&
                     wa < 13'(MEM_SIZE);

  always_ff @(posedge mclk) begin
    if (bus_wr_ok) begin
      mem[wa]              <= bus_req.wdata[15:8];
      mem[13'(wa + 13'd1)] <= bus_req.wdata[7:0];
    end
    if (hw_en)
      mem[hw_addr] <= hw_data;
  end

  // control bytes seen live from memory; a write landing this cycle shows the next cycle
  always_comb begin
    ctl_clr  = mem[`CLR_CTRL_ADDR];
    ctl_poll = mem[`POLL_EN_ADDR];
    ctl_trig = mem[`TRIG_LABEL_ADDR];
    ctl_tcmd = mem[`TRIG_CMD_ADDR];
    ctl_ptx  = mem[`PTX_LABEL_ADDR];
    ctl_pen  = mem[`PTX_EN_ADDR];
    ctl_plen = {mem[`PTX_LEN_ADDR], mem[13'(`PTX_LEN_ADDR + 13'd1)]};
    tx_byte  = mem[s_q.tx_ptr];
  end

  // ==========================================================
  // next state
  // ==========================================================
  logic clr_hit, trig_hit, ptx_hit, pt_on;
  logic [12:0] ra;

  always_comb begin
    s_d = s_q;
    hw_en = 1'b0;
    hw_addr = 13'h0000;
    hw_data = 8'h00;
    hart_tx = '0;
    hart_cmd_start = 1'b0;
    ser_frame_end = 1'b0;
    ra = hi_byte(bus_req.reg_addr);
    pt_on = (ctl_pen == `PASSTHRU_ON);
    clr_hit = (ctl_clr != s_q.clr_shadow);
    trig_hit = (ctl_trig != s_q.trig_shadow);
    ptx_hit = (ctl_ptx != s_q.ptx_shadow);

    // register reads; status bytes come from live state
    s_d.rvalid = bus_req.rd;
    if (bus_req.rd) begin
      if (ra == `GW_STATE_ADDR)
        s_d.rdata = {6'h00, s_q.gw, s_q.send_cnt};
      else if (ra == `RECV_CNT_ADDR)
        s_d.rdata = {s_q.recv_cnt, s_q.err_cnt};
      else if (ra == `PRX_LABEL_ADDR)
        s_d.rdata = {s_q.prx_label, s_q.prx_err};
      else if (ra == `PRX_LEN_ADDR)
        s_d.rdata = s_q.prx_len;
      else if (ra < 13'(MEM_SIZE))
        s_d.rdata = {mem[ra], mem[13'(ra + 13'd1)]};
      else
        s_d.rdata = 16'h0000;
    end

    // counters; later bumps start from the cleared copy, so a clear
    // and an event in one cycle leave the count at one
    if (clr_hit) begin
      s_d.clr_shadow = ctl_clr;
      s_d.send_cnt = 8'h00;
      s_d.recv_cnt = 8'h00;
      s_d.err_cnt = 8'h00;
    end

    // serial idle timer for universal serial mode
    if (ser_mode_universal && ser_rx.valid) begin
      s_d.idle_cnt = 16'h0000;
      s_d.ser_active = 1'b1;
    end else if (s_q.ser_active) begin
      if (s_q.idle_cnt >= IDLE_CYC) begin
        ser_frame_end = 1'b1;
        s_d.ser_active = 1'b0;
      end else
        s_d.idle_cnt = 16'(s_q.idle_cnt + 16'd1);
    end

    case (s_q.act)
      A_IDLE: begin
        s_d.gw = GW_IDLE;
        if (pt_on && ptx_hit) begin
          s_d.ptx_shadow = ctl_ptx;
          s_d.tx_len = (ctl_plen > `PRX_DATA_MAX) ? `PRX_DATA_MAX : ctl_plen;
          s_d.tx_idx = 16'h0000;
          s_d.tx_ptr = `PTX_DATA_BASE;
          s_d.rx_base = `PRX_DATA_BASE;
          s_d.stat_addr = 13'h0000;
          s_d.act = A_PT_SEND;
          s_d.gw = GW_SENDING;
        end else if (!pt_on && ptx_hit) begin
          s_d.ptx_shadow = ctl_ptx;
        end else if (cmd_req && !s_q.ident_seen[cmd_slave]) begin
          s_d.cur_slave = cmd_slave;
          s_d.rx_base = 13'(`IDENT_BASE + {9'h000, cmd_slave} * `IDENT_SIZE);
          s_d.stat_addr = 13'(`IDENT_STAT_BASE + {9'h000, cmd_slave});
          s_d.cur_cmd = 8'h00;
          s_d.act = A_IDENT;
          s_d.gw = GW_SENDING;
          hart_cmd_start = 1'b1;
        end else if (trig_hit && !s_q.ident_seen[s_q.cur_slave]) begin
          // trigger label stays pending until the identity run is over
          s_d.rx_base = 13'(`IDENT_BASE + {9'h000, s_q.cur_slave} *
                        `IDENT_SIZE);
          s_d.stat_addr = 13'(`IDENT_STAT_BASE + {9'h000, s_q.cur_slave});
          s_d.cur_cmd = 8'h00;
          s_d.act = A_IDENT;
          s_d.gw = GW_SENDING;
          hart_cmd_start = 1'b1;
        end else if (trig_hit) begin
          s_d.trig_shadow = ctl_trig;
          s_d.cur_cmd = ctl_tcmd;
          s_d.rx_base = 13'(USER_RX_BASE +
                        13'({5'h00, ctl_tcmd} * USER_RX_SIZE));
          s_d.stat_addr = 13'(`USER_STAT_BASE + {5'h00, ctl_tcmd});
          s_d.act = A_TRIG;
          s_d.gw = GW_SENDING;
          hart_cmd_start = 1'b1;
        end else if (cmd_req) begin
          s_d.cur_cmd = cmd_req_num;
          s_d.cur_slave = cmd_slave;
          s_d.rx_base = 13'(USER_RX_BASE +
                        13'({5'h00, cmd_req_num} * USER_RX_SIZE));
          s_d.stat_addr = 13'(`USER_STAT_BASE + {5'h00, cmd_req_num});
          s_d.act = A_TRIG;
          s_d.gw = GW_SENDING;
          hart_cmd_start = 1'b1;
        end
        s_d.rx_idx = 16'h0000;
      end
      A_PT_SEND: begin
        if (s_q.tx_idx < s_q.tx_len) begin
          hart_tx.valid = 1'b1;
          hart_tx.data = tx_byte;
          hart_tx.last = (16'(s_q.tx_idx + 16'd1) == s_q.tx_len);
          if (hart_tx_ready) begin
            s_d.tx_idx = 16'(s_q.tx_idx + 16'd1);
            s_d.tx_ptr = 13'(s_q.tx_ptr + 13'd1);
          end
        end else begin
          s_d.send_cnt = bump(s_d.send_cnt);
          s_d.act = A_WAIT;
          s_d.gw = GW_WAITING;
        end
      end
      A_IDENT, A_TRIG: begin
        if (hart_tx_ready) begin
          s_d.send_cnt = bump(s_d.send_cnt);
          s_d.act = A_WAIT;
          s_d.gw = GW_WAITING;
          if (s_q.act == A_IDENT)
            s_d.ident_seen[s_q.cur_slave] = 1'b1;
        end
      end
      A_WAIT: begin
        if (hart_rx.valid) begin
          s_d.gw = GW_HANDLING;
          if ((s_q.stat_addr != 13'h0000 && s_q.rx_idx < 16'(IDENT_LEN)) ||
              (s_q.stat_addr == 13'h0000 && s_q.rx_idx < `PRX_DATA_MAX)) begin
            hw_en = 1'b1;
            hw_addr = 13'(s_q.rx_base + s_q.rx_idx[12:0]);
            hw_data = hart_rx.data;
            s_d.rx_idx = 16'(s_q.rx_idx + 16'd1);
          end
        end else if (hart_done.valid) begin
          s_d.act = A_IDLE;
          s_d.gw = GW_IDLE;
          if (hart_done.status == ST_OK)
            s_d.recv_cnt = bump(s_d.recv_cnt);
          else
            s_d.err_cnt = bump(s_d.err_cnt);
          if (s_q.stat_addr == 13'h0000) begin
            if (hart_done.status == ST_OK) begin
              s_d.prx_len = s_q.rx_idx;
              s_d.prx_label = bump(s_q.prx_label);
            end else
              s_d.prx_err = bump(s_q.prx_err);
          end else begin
            hw_en = 1'b1;
            hw_addr = s_q.stat_addr;
            hw_data = {5'h00, hart_done.status};
          end
        end
      end
      default: s_d.act = A_IDLE;
    endcase
    // prx_label changes in the same cycle that prx_len is stored
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rdata    = s_q.rdata;
  assign bus_rvalid   = s_q.rvalid;
  assign poll_enabled = (ctl_poll == 8'h01);
  assign gw_state     = s_q.gw;
  assign hart_cmd     = s_q.cur_cmd;
  assign hart_slave   = s_q.cur_slave;
  assign hart_ident   = (s_q.act == A_IDENT);
endmodule
`default_nettype wire

//--- fieldbus_exchange_memory_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fieldbus_exchange_memory_bench;
  import xchg_pkg::*;
  localparam int BAUD = 1000000;
  logic        mclk, sys_rst, ser_mode_universal, rvalid, frame_end;
  logic        tx_ready, cmd_start, ident, poll_en, slow, mute, idf;
  logic [15:0] rdata, v, old, d;
  logic [11:0] a;
  logic [7:0]  cmd;
  logic [3:0]  slave;
  bus_req_t    req;
  hart_byte_t  ser_rx, hart_tx, hart_rx;
  hart_done_t  done;
  gw_state_t   gw;
  logic [7:0]  q[$];
  int          err_count, checked, seed, n, i;
  fieldbus_exchange_memory #(.BAUD(BAUD)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .bus_req(req), .bus_rdata(rdata),
    .bus_rvalid(rvalid), .ser_mode_universal(ser_mode_universal),
    .ser_rx(ser_rx), .ser_frame_end(frame_end), .hart_tx(hart_tx),
    .hart_tx_ready(tx_ready), .hart_cmd(cmd), .hart_cmd_start(cmd_start),
    .hart_slave(slave), .hart_ident(ident), .hart_rx(hart_rx),
    .hart_done(done), .cmd_slave(4'h0), .cmd_req(1'b0),
    .cmd_req_num(8'h00), .poll_enabled(poll_en), .gw_state(gw));
  hart_slave_model far (.mclk(mclk), .sys_rst(sys_rst), .hart_tx(hart_tx),
    .hart_cmd_start(cmd_start), .hart_tx_ready(tx_ready), .hart_rx(hart_rx),
    .hart_done(done), .slow(slow), .mute(mute));
  // ==========================
  // helpers
  function automatic int idle_cycles(int b);
    return 20000000 / b * 35;
  endfunction
  task automatic check(input logic [15:0] seen, exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] ad, input logic [15:0] wd);
    @(negedge mclk) req = '{1'b0, 1'b1, ad, wd};
    @(negedge mclk) req.wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] ad);
    @(negedge mclk) req = '{1'b1, 1'b0, ad, 16'h0000};
    @(negedge mclk) req.rd = 1'b0;
    check({15'h0000, rvalid}, 16'h0001, "rvalid");
    v = rdata;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk) if (hart_tx.valid && tx_ready) q.push_back(hart_tx.data);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #4_000_000 err_count++;
    summarize();
  end
  // ==========================
  // scenarios
  initial begin
    seed = 32'hcedc8b75; req = '0; ser_rx = '0; ser_mode_universal = 1'b0;
    slow = 1'b1; mute = 1'b0; idf = 1'b0; err_count = 0; checked = 0;
    sys_rst = 1'b1;
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    wr(12'd960, 16'hFFFF);
    rd(12'd960); check(v, 16'h0000, "state_sent");
    rd(12'd2600); check(v, 16'h0000, "unmapped");
    for (i = 0; i < 10; i++) begin
      n = $unsigned($random(seed)) % 500;
      a = (i == 0) ? 12'd1500 : (i == 1) ? 12'd2499 : 12'(1500 + n);
      d = 16'($random(seed));
      wr(a, d); rd(a); check(v, d, "rw_word");
    end
    wr(12'd2000, 16'h0001); check({15'h0000, poll_en}, 16'h0001, "poll");
    rd(12'd2000); check(v, 16'h0001, "poll_rd");
    wr(12'd2135, 16'h0001); wr(12'd2136, 16'h0003);
    wr(12'd2137, 16'hA1B2); wr(12'd2138, 16'hC3D4);
    rd(12'd1196); old = v; q.delete();
    wr(12'd2135, 16'h0101);
    for (int k = 0; k < 100 && v === old; k++) rd(12'd1196);
    check(16'(q.size()), 16'h0003, "tx_count");
    check({q[0], q[1]}, 16'hA1B2, "tx_bytes");
    check({q[2], 8'h00}, 16'hC300, "tx_tail");
    check(v, old + 16'h0100, "rx_label");
    rd(12'd1197); check(v, 16'h0002, "rx_len");
    rd(12'd1198); check(v, 16'h5AA5, "rx_data");
    rd(12'd960); check(v, 16'h0001, "sent");
    rd(12'd961); check(v, 16'h0100, "recv_err");
    mute = 1'b1; slow = 1'b0; old = v;
    rd(12'd1196); old = v;
    wr(12'd2135, 16'h0201);
    for (int k = 0; k < 100 && v === old; k++) rd(12'd1196);
    check(v, old + 16'h0001, "rx_errors");
    rd(12'd961); check(v, 16'h0101, "hart_errors");
    wr(12'd2135, 16'h0200); q.delete(); wr(12'd2135, 16'h0300);
    repeat (60) @(negedge mclk);
    check(16'(q.size()), 16'h0000, "disabled_tx");
    wr(12'd2000, 16'h5500); check({15'h0000, poll_en}, 16'h0000, "poll");
    rd(12'd960); check(v, 16'h0000, "cleared");
    rd(12'd961); check(v, 16'h0000, "cleared2");
    mute = 1'b0;
    wr(12'd2001, 16'h0102); n = 0;
    // identity run first, then the triggered command's own start
    while (!(cmd_start && idf) && n < 600) begin
      @(negedge mclk) n++;
      if (ident) idf = 1'b1;
    end
    @(negedge mclk);
    check({8'h00, cmd}, 16'h0002, "trigger_cmd");
    check({12'h000, slave}, 16'h0000, "trigger_slave");
    check({14'h0000, gw}, 16'h0001, "gw_sending");
    check({15'h0000, idf}, 16'h0001, "identity_first");
    repeat (30) @(negedge mclk);
    rd(12'd800); check(v, 16'h5AA5, "identity_data");
    rd(12'd972); check(v & 16'hFF00, 16'h0100, "identity_status");
    rd(12'd20); check(v, 16'h5AA5, "trigger_data");
    rd(12'd981); check(v & 16'hFF00, 16'h0100, "trigger_status");
    ser_mode_universal = 1'b1;
    @(negedge mclk) ser_rx = '{1'b1, 1'b0, 8'h3A};
    @(negedge mclk) ser_rx.valid = 1'b0;
    n = 0;
    while (!frame_end && n < 2000) @(negedge mclk) n++;
    check({15'h0000, n >= idle_cycles(BAUD) - 3 && n <= idle_cycles(BAUD) + 3},
          16'h0001, "idle_timeout");
    summarize();
  end
endmodule
`default_nettype wire

//--- fieldbus_exchange_memory_props.sv
`timescale 1ns/1ps
`default_nettype none
module fieldbus_exchange_memory_props
  import xchg_pkg::*;
(
  // system
  input wire logic       mclk,
  input wire logic       sys_rst,
  // watched ports
  input wire bus_req_t   bus_req,
  input wire logic       bus_rvalid,
  input wire logic       ser_mode_universal,
  input wire logic       ser_frame_end,
  input wire hart_byte_t hart_tx,
  input wire logic       hart_tx_ready,
  input wire logic       poll_enabled,
  input wire gw_state_t  gw_state
);
  // ==========================
  // properties
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_read;
    bus_req.rd;
  endsequence
  sequence s_poll_wr;
    bus_req.wr && bus_req.reg_addr == 12'h7D0;
  endsequence
  sequence s_stall;
    hart_tx.valid && !hart_tx_ready;
  endsequence
  chk_read_answer: assert property (s_read |=> bus_rvalid)
    else $error("read not answered");
  chk_answer_only: assert property (!bus_req.rd |=> !bus_rvalid)
    else $error("answer without read");
  chk_poll_on: assert property (
    s_poll_wr ##0 bus_req.wdata[7:0] == 8'h01 |=> poll_enabled)
    else $error("poll not on");
  chk_poll_off: assert property (
    s_poll_wr ##0 bus_req.wdata[7:0] == 8'h00 |=> !poll_enabled)
    else $error("poll not off");
  // memory is not reset, so hold checks start from a defined level
  chk_poll_hold_on: assert property (
    !bus_req.wr && poll_enabled |=> poll_enabled)
    else $error("poll dropped alone");
  chk_poll_hold_off: assert property (
    !bus_req.wr && !poll_enabled |=> !poll_enabled)
    else $error("poll rose alone");
  chk_tx_hold: assert property (
    s_stall |=> hart_tx.valid && $stable(hart_tx.data))
    else $error("tx byte dropped");
  chk_tx_state: assert property (hart_tx.valid |-> gw_state == GW_SENDING)
    else $error("tx outside sending");
  chk_frame_mode: assert property (ser_frame_end |-> ser_mode_universal)
    else $error("frame end outside mode");
endmodule
bind fieldbus_exchange_memory fieldbus_exchange_memory_props chk (
  .mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rvalid(bus_rvalid),
  .ser_mode_universal(ser_mode_universal), .ser_frame_end(ser_frame_end),
  .hart_tx(hart_tx), .hart_tx_ready(hart_tx_ready),
  .poll_enabled(poll_enabled), .gw_state(gw_state));
`default_nettype wire

//--- hart_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module hart_slave_model
  import xchg_pkg::*;
(
  // system
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // frames from the gateway
  input  wire hart_byte_t hart_tx,
  input  wire logic       hart_cmd_start,
  output var  logic       hart_tx_ready,
  // replies
  output var  hart_byte_t hart_rx,
  output var  hart_done_t hart_done,
  // test controls
  input  wire logic       slow,
  input  wire logic       mute
);
  logic [1:0] div_q;
  int         wait_q;
  assign hart_tx_ready = !slow || div_q == 2'd0;
  always_ff @(posedge mclk) begin
    div_q <= div_q + 2'd1;
    hart_done <= '0;
    hart_rx.valid <= 1'b0;
    hart_rx.last <= 1'b0;
    // a released data line never holds its old byte
    hart_rx.data <= ~hart_rx.data;
    if (sys_rst) begin
      wait_q <= 0;
      div_q <= 2'd0;
      hart_rx.data <= 8'h3C;
    end else if ((hart_tx.valid && hart_tx.last && hart_tx_ready)
                 || hart_cmd_start) begin
      wait_q <= 1;
    end else if (wait_q != 0) begin
      wait_q <= wait_q + 1;
      if (wait_q == 8 && !mute) hart_rx <= '{1'b1, 1'b0, 8'h5A};
      if (wait_q == 9 && !mute) hart_rx <= '{1'b1, 1'b1, 8'hA5};
      if (wait_q == 10) begin
        hart_done <= '{1'b1, mute ? ST_NO_ANSWER : ST_OK};
        wait_q <= 0;
      end
    end
  end
endmodule
`default_nettype wire

//--- xchg_defs.svh
`ifndef XCHG_DEFS_SVH
`define XCHG_DEFS_SVH
// memory map (byte addresses)
`define MEM_BYTES        5000
`define RO_LAST          13'd2999
`define RW_FIRST         13'd3000
`define IDENT_BASE       13'd1600
`define IDENT_SIZE       13'd20
`define GW_STATE_ADDR    13'd1920
`define SEND_CNT_ADDR    13'd1921
`define RECV_CNT_ADDR    13'd1922
`define ERR_CNT_ADDR     13'd1923
`define IDENT_STAT_BASE  13'd1944
`define USER_STAT_BASE   13'd1960
`define PRX_LABEL_ADDR   13'd2392
`define PRX_ERR_ADDR     13'd2393
`define PRX_LEN_ADDR     13'd2394
`define PRX_DATA_BASE    13'd2396
`define PRX_DATA_MAX     16'd300
`define CLR_CTRL_ADDR    13'd4000
`define POLL_EN_ADDR     13'd4001
`define TRIG_LABEL_ADDR  13'd4002
`define TRIG_CMD_ADDR    13'd4003
`define PTX_LABEL_ADDR   13'd4270
`define PTX_EN_ADDR      13'd4271
`define PTX_LEN_ADDR     13'd4272
`define PTX_DATA_BASE    13'd4274
`define PASSTHRU_ON      8'h01
// serial idle timeout: 3.5 chars of 10 bits, in tenths of a char
`define IDLE_TENTH_BITS  35
`define BITS_PER_CHAR    10
`define CLK_HZ           20000000
`endif

//--- xchg_pkg.sv
package xchg_pkg;
  typedef enum logic [1:0] {
    GW_IDLE, GW_SENDING, GW_WAITING, GW_HANDLING
  } gw_state_t;
  typedef enum logic [2:0] {
    ST_NOT_RUN, ST_OK, ST_PARITY, ST_NO_ANSWER, ST_PROTO_ERR, ST_NOT_CONN
  } cmd_status_t;
  typedef enum logic [2:0] {
    A_IDLE, A_PT_SEND, A_WAIT, A_TRIG, A_IDENT
  } act_t;
  // bus register port
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] reg_addr;
    logic [15:0] wdata;
  } bus_req_t;
  // hart link, byte stream each way
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } hart_byte_t;
  // result of one hart transaction
  typedef struct packed {
    logic        valid;
    cmd_status_t status;
  } hart_done_t;
  typedef struct packed {
    gw_state_t   gw;
    act_t        act;
    logic [7:0]  send_cnt;
    logic [7:0]  recv_cnt;
    logic [7:0]  err_cnt;
    logic [7:0]  clr_shadow;
    logic [7:0]  trig_shadow;
    logic [7:0]  ptx_shadow;
    logic [7:0]  prx_label;
    logic [7:0]  prx_err;
    logic [15:0] prx_len;
    logic [15:0] tx_idx;
    logic [15:0] tx_len;
    logic [12:0] tx_ptr;
    logic [7:0]  cur_cmd;
    logic [3:0]  cur_slave;
    logic [15:0] ident_seen;
    logic [15:0] rx_idx;
    logic [12:0] rx_base;
    logic [12:0] stat_addr;
    logic [15:0] rdata;
    logic        rvalid;
    logic [15:0] idle_cnt;
    logic        ser_active;
  } state_t;
endpackage
